// ---- ifs_bank_two.sv ----
// Interrupt flag bank two: sticky flags, mask, bus slave and interrupt line
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - A source request sets its flag until changed
// - A zero flag means nothing pending
// - Output compare seven flag sits at bit 11
// - Output compare five flag sits at bit 9
// - Input capture six flag sits at bit 8
// - Input capture three flag sits at bit 5
// - CAN one receive-ready flag sits at bit 2
// - SPI two event flag sits at bit 1
// - SPI two error flag sits at bit 0
module ifs_bank_two
   import ifs_bank_two_pkg::*;
(
   input  wire logic                      CLK_SYS_I,
   input  wire logic                      ARST_N_I,
   input  wire logic [BUS_ADDR_WIDTH-1:0] AVS_ADDRESS_I,
   input  wire logic                      AVS_READ_I,
   input  wire logic                      AVS_WRITE_I,
   input  wire logic [BUS_DATA_WIDTH-1:0] AVS_WRITEDATA_I,
   input  wire logic [3:0]                AVS_BYTEENABLE_I,
   output logic      [BUS_DATA_WIDTH-1:0] AVS_READDATA_O,
   output logic                           AVS_WAITREQUEST_O,
   input  wire flag_bits_type             SRC_REQ_I,
   output flag_bits_type                  FLAGS_O,
   output logic                           IRQ_O
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic hit(input logic [3:0] addr,
                                input logic [3:0] ofs);
      hit = (addr == ofs);
   endfunction

   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic        ack;
   logic        bus_req;
   logic        do_write;
   logic [15:0] lanes;
   logic [15:0] src_vec;
   logic [15:0] flag_vec;
   logic [15:0] mask;
   logic [15:0] wr_en;
   logic [15:0] clr_vec;
   logic [15:0] pending;
   logic [15:0] next_read;

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: every access answers on its second cycle

   assign bus_req           = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = bus_req & ~ack;
   assign do_write          = AVS_WRITE_I & ack;
   assign lanes             = lane_mask(AVS_BYTEENABLE_I);

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ack <= 1'b0;
      end else begin
         ack <= bus_req & ~ack;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write decode

   // Lanes above bit 15 carry nothing; unmapped writes are dropped
   always_comb begin
      wr_en   = 16'h0000;
      clr_vec = 16'h0000;
      if (do_write && hit(AVS_ADDRESS_I, OFS_FLAGS)) begin
         wr_en = lanes & FLAG_IMPL_MASK;
      end
      if (do_write && hit(AVS_ADDRESS_I, OFS_FLAGS_CLR)) begin
         clr_vec = lanes & AVS_WRITEDATA_I[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag cells

   // Struct order fixes every flag at its bit position
   assign src_vec = SRC_REQ_I;

   for (genvar g = 0; g < FLAG_WIDTH; g++) begin : g_flag
      sticky_flag_cell #(
         .IMPLEMENTED (FLAG_IMPL_MASK[g])
      ) u_cell (
         .clk_i    (CLK_SYS_I),
         .arst_n_i (ARST_N_I),
         .set_i    (src_vec[g]),
         .wr_en_i  (wr_en[g]),
         .wr_val_i (AVS_WRITEDATA_I[g]),
         .clr_i    (clr_vec[g]),
         .flag_o   (flag_vec[g])
      );
   end

   assign FLAGS_O = flag_bits_type'(flag_vec);

   ////////////////////////////////////////////////////////////////////////
   // Mask register and interrupt line

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mask <= MASK_RESET;
      end else if (do_write && hit(AVS_ADDRESS_I, OFS_MASK)) begin
         mask <= (mask & ~lanes) | (AVS_WRITEDATA_I[15:0] & lanes & FLAG_IMPL_MASK);
      end
   end

   // Level output; a zero flag can never hold it up
   assign pending = flag_vec & mask;
   assign IRQ_O   = |pending;

   ////////////////////////////////////////////////////////////////////////
   // Read path

   // Sampled on the first cycle of the access, so a write on the same
   // cycle as the answer is not yet visible in the returned word
   always_comb begin
      next_read = 16'h0000;
      case (AVS_ADDRESS_I)
         OFS_FLAGS:     next_read = flag_vec;
         OFS_FLAGS_CLR: next_read = flag_vec;
         OFS_MASK:      next_read = mask;
         OFS_PENDING:   next_read = pending;
         default:       next_read = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         AVS_READDATA_O <= 32'h0000_0000;
      end else if (AVS_READ_I && !ack) begin
         AVS_READDATA_O <= {16'h0000, next_read & FLAG_IMPL_MASK};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!ARST_N_I);

   sequence s_req_start;
      (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
   endsequence

   sequence s_req_answer;
      (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O;
   endsequence

   sequence s_clr_write(int pos);
      do_write && hit(AVS_ADDRESS_I, OFS_FLAGS_CLR) && AVS_WRITEDATA_I[pos]
         && lanes[pos];
   endsequence

   chk_bus_answer_time: assert property (
      s_req_start |=> s_req_answer)
      else $error("Bus access not answered on its second cycle");

   chk_flag_sets_on_req: assert property (
      (src_vec & FLAG_IMPL_MASK) != 16'h0000
         |=> (flag_vec & $past(src_vec) & FLAG_IMPL_MASK)
             == ($past(src_vec) & FLAG_IMPL_MASK))
      else $error("Requested flag not set next cycle");

   chk_flag_stays_set: assert property (
      1'b1 |=> (($past(flag_vec) & ~$past(wr_en) & ~$past(clr_vec))
                & ~flag_vec) == 16'h0000)
      else $error("Flag dropped without a software change");

   chk_clear_then_zero: assert property (
      s_clr_write(POS_SPI_ERROR) ##0 !src_vec[POS_SPI_ERROR]
         |=> !flag_vec[POS_SPI_ERROR] ##0 !pending[POS_SPI_ERROR])
      else $error("Cleared flag still pending");

   chk_irq_needs_flag: assert property (
      flag_vec == 16'h0000 |-> !IRQ_O)
      else $error("Interrupt high with no flag set");

   chk_oc_seven_pos: assert property (
      SRC_REQ_I.out_cmp_seven_flag |=> flag_vec[11] && FLAGS_O.out_cmp_seven_flag)
      else $error("Output compare seven flag not at bit 11");

   chk_oc_five_pos: assert property (
      SRC_REQ_I.out_cmp_five_flag |=> flag_vec[9])
      else $error("Output compare five flag not at bit 9");

   chk_ic_six_pos: assert property (
      SRC_REQ_I.in_cap_six_flag |=> flag_vec[8])
      else $error("Input capture six flag not at bit 8");

   chk_ic_three_pos: assert property (
      SRC_REQ_I.in_cap_three_flag |=> flag_vec[5])
      else $error("Input capture three flag not at bit 5");

   chk_can_rx_pos: assert property (
      SRC_REQ_I.can_one_rx_ready_flag |=> flag_vec[2])
      else $error("CAN one receive flag not at bit 2");

   chk_spi_event_pos: assert property (
      SRC_REQ_I.spi_two_event_flag |=> flag_vec[1])
      else $error("SPI two event flag not at bit 1");

   chk_spi_error_pos: assert property (
      SRC_REQ_I.spi_two_error_flag |=> flag_vec[0])
      else $error("SPI two error flag not at bit 0");

   chk_unused_bit_zero: assert property (
      !flag_vec[13] && !mask[13] && !AVS_READDATA_O[13])
      else $error("Unused bit 13 reads as one");

   chk_sw_write_flag: assert property (
      do_write && hit(AVS_ADDRESS_I, OFS_FLAGS) && lanes[POS_CAN_EVENT]
         && !src_vec[POS_CAN_EVENT]
         |=> flag_vec[POS_CAN_EVENT] == $past(AVS_WRITEDATA_I[POS_CAN_EVENT]))
      else $error("Software write to a flag not taken");

   chk_read_answer: assert property (
      AVS_READ_I && !ack && hit(AVS_ADDRESS_I, OFS_MASK)
         |=> !AVS_WAITREQUEST_O && AVS_READDATA_O[15:0] == $past(mask))
      else $error("Mask read returned wrong data");

   ////////////////////////////////////////////////////////////////////////
   // Reset, lane and read data checks

   sequence s_read_first(logic [3:0] ofs);
      AVS_READ_I && !ack && hit(AVS_ADDRESS_I, ofs);
   endsequence

   // Runs with the default disable lifted; the first edge of a reset is
   // skipped, since the flops may only meet the reset at that edge
   chk_reset_clears_all: assert property (
      disable iff (1'b0)
      !ARST_N_I && !$past(ARST_N_I)
         |-> flag_vec == FLAGS_RESET && mask == MASK_RESET && !IRQ_O
             && AVS_READDATA_O == 32'h0000_0000)
      else $error("State not cleared while reset is held");

   chk_lane_keeps_flag: assert property (
      do_write && hit(AVS_ADDRESS_I, OFS_FLAGS) && !lanes[POS_TIMER_SIX]
         && !src_vec[POS_TIMER_SIX]
         |=> flag_vec[POS_TIMER_SIX] == $past(flag_vec[POS_TIMER_SIX]))
      else $error("Write on a disabled lane changed a flag");

   chk_set_beats_clear: assert property (
      s_clr_write(POS_DMA_THREE) ##0 src_vec[POS_DMA_THREE]
         |=> flag_vec[POS_DMA_THREE])
      else $error("Software clear won over a new request");

   chk_flag_read_data: assert property (
      s_read_first(OFS_FLAGS)
         |=> AVS_READDATA_O[15:0] == $past(flag_vec))
      else $error("Flag read returned wrong data");

   chk_clr_reads_flags: assert property (
      s_read_first(OFS_FLAGS_CLR)
         |=> AVS_READDATA_O[15:0] == $past(flag_vec))
      else $error("Clear offset read did not return the flags");

   chk_pending_read: assert property (
      s_read_first(OFS_PENDING)
         |=> AVS_READDATA_O[15:0] == ($past(flag_vec) & $past(mask)))
      else $error("Pending read returned wrong data");

   chk_unmapped_read: assert property (
      AVS_READ_I && !ack && AVS_ADDRESS_I[1:0] != 2'b00
         |=> AVS_READDATA_O == 32'h0000_0000)
      else $error("Unmapped read returned nonzero data");

   chk_upper_half_zero: assert property (
      AVS_READDATA_O[31:16] == 16'h0000)
      else $error("Upper read half not zero");

   chk_mask_write: assert property (
      do_write && hit(AVS_ADDRESS_I, OFS_MASK) && lanes[POS_SPI_EVENT]
         |=> mask[POS_SPI_EVENT] == $past(AVS_WRITEDATA_I[POS_SPI_EVENT]))
      else $error("Mask write not taken");

   chk_clear_drops_flag: assert property (
      do_write && hit(AVS_ADDRESS_I, OFS_FLAGS_CLR)
         |=> (flag_vec & $past(clr_vec) & ~$past(src_vec)) == 16'h0000)
      else $error("Write-one-to-clear left a flag set");

   chk_zero_means_idle: assert property (
      (~flag_vec & $past(src_vec) & FLAG_IMPL_MASK) == 16'h0000)
      else $error("Flag reads zero after a request");

   chk_idle_no_wait: assert property (
      !AVS_READ_I && !AVS_WRITE_I |-> !AVS_WAITREQUEST_O)
      else $error("Waitrequest high with the bus idle");

endmodule
`default_nettype wire

// ---- ifs_bank_two_pkg.sv ----
// Constants, register map and carrier types for the second flag bank
package ifs_bank_two_pkg;

   localparam int          FLAG_WIDTH     = 16;
   localparam int          BUS_ADDR_WIDTH = 4;
   localparam int          BUS_DATA_WIDTH = 32;

   // Byte offsets on the register bus
   localparam logic [3:0]  OFS_FLAGS      = 4'h0;
   localparam logic [3:0]  OFS_MASK       = 4'h4;
   localparam logic [3:0]  OFS_FLAGS_CLR  = 4'h8;
   localparam logic [3:0]  OFS_PENDING    = 4'hc;

   // Reset values
   localparam logic [15:0] FLAGS_RESET    = 16'h0000;
   localparam logic [15:0] MASK_RESET     = 16'h0000;

   // Bit positions of the flags
   localparam int          POS_TIMER_SIX  = 15;
   localparam int          POS_DMA_FOUR   = 14;
   localparam int          POS_UNUSED     = 13;
   localparam int          POS_OC_EIGHT   = 12;
   localparam int          POS_OC_SEVEN   = 11;
   localparam int          POS_OC_SIX     = 10;
   localparam int          POS_OC_FIVE    = 9;
   localparam int          POS_IC_SIX     = 8;
   localparam int          POS_IC_FIVE    = 7;
   localparam int          POS_IC_FOUR    = 6;
   localparam int          POS_IC_THREE   = 5;
   localparam int          POS_DMA_THREE  = 4;
   localparam int          POS_CAN_EVENT  = 3;
   localparam int          POS_CAN_RX     = 2;
   localparam int          POS_SPI_EVENT  = 1;
   localparam int          POS_SPI_ERROR  = 0;

   // Every bit except the unused slot holds a flag
   localparam logic [15:0] FLAG_IMPL_MASK = 16'hdfff;

   // Field order follows the bit positions, bit 15 first
   typedef struct packed {
      logic timer_six_request_flag;
      logic dma_ch_four_done_flag;
      logic unused_slot;
      logic out_cmp_eight_flag;
      logic out_cmp_seven_flag;
      logic out_cmp_six_flag;
      logic out_cmp_five_flag;
      logic in_cap_six_flag;
      logic in_cap_five_flag;
      logic in_cap_four_flag;
      logic in_cap_three_flag;
      logic dma_ch_three_done_flag;
      logic can_one_event_flag;
      logic can_one_rx_ready_flag;
      logic spi_two_event_flag;
      logic spi_two_error_flag;
   } flag_bits_type;

endpackage

// ---- ifs_bank_two_test.sv ----
// Self-checking bench for the second flag bank
`timescale 1ns/1ps
`default_nettype none
module ifs_bank_two_test;
   import ifs_bank_two_pkg::*;
   logic          clk;
   logic          arst_n;
   logic          rd;
   logic          wr;
   logic [3:0]    addr;
   logic [3:0]    be;
   logic [31:0]   wdata;
   logic [31:0]   rdata;
   logic          waitreq;
   logic          irq;
   flag_bits_type fire;
   flag_bits_type src;
   flag_bits_type flags;
   int            miscompares;
   int            checked;

   ////////////////////////////////////////////////////////////////////////////
   ifs_bank_two DUT (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .SRC_REQ_I(src), .FLAGS_O(flags), .IRQ_O(irq));
   src_req_model peer (.clk_i(clk), .arst_n_i(arst_n), .fire_i(fire), .req_o(src));

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (miscompares == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
      checked++;
      if (act !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, act);
         miscompares++;
      end
   endtask

   // Holds the request until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge clk);
      rd    <= !w;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      be    <= b;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) chk("waitrequest", 32'h0, {31'h0, waitreq});
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      logic [31:0] q;
      bus(1'b1, a, d, b, q);
   endtask

   task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk(what, exp, q);
   endtask

   task automatic pulse(input logic [15:0] v);
      @(posedge clk);
      fire <= v;
      @(posedge clk);
      fire <= '0;
      repeat (4) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_chk("flags", OFS_FLAGS, 32'h0);
      rd_chk("mask", OFS_MASK, 32'h0);
      rd_chk("pending", OFS_PENDING, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
   endtask

   // Flag must stay up well after the request pulse, then clear to zero
   task automatic t_source(input logic [15:0] v, input logic [15:0] exp);
      pulse(v);
      rd_chk("flags", OFS_FLAGS, {16'h0, exp});
      chk("flags_o", {16'h0, exp}, {16'h0, flags});
      wr_reg(OFS_FLAGS_CLR, {16'h0, v}, 4'hf);
      rd_chk("cleared", OFS_FLAGS, 32'h0);
   endtask

   task automatic t_sw;
      wr_reg(OFS_FLAGS, 32'hffff_ffff, 4'hf);
      rd_chk("sw set", OFS_FLAGS, 32'h0000_dfff);
      wr_reg(OFS_FLAGS, 32'h0, 4'h1);
      rd_chk("low lane", OFS_FLAGS, 32'h0000_df00);
      wr_reg(OFS_FLAGS, 32'h0, 4'hf);
      rd_chk("sw clear", OFS_FLAGS, 32'h0);
      wr_reg(OFS_FLAGS, 32'h0000_ffff, 4'h2);
      rd_chk("high lane", OFS_FLAGS, 32'h0000_df00);
      wr_reg(OFS_FLAGS_CLR, 32'h0000_ffff, 4'h1);
      rd_chk("clr low lane", OFS_FLAGS, 32'h0000_df00);
      wr_reg(OFS_FLAGS_CLR, 32'h0000_ffff, 4'h2);
      rd_chk("clr high lane", OFS_FLAGS, 32'h0);
      wr_reg(4'h2, 32'hffff_ffff, 4'hf);
      rd_chk("unmapped", 4'h2, 32'h0);
      rd_chk("flags", OFS_FLAGS, 32'h0);
   endtask

   task automatic t_irq;
      wr_reg(OFS_MASK, 32'h0000_ffff, 4'hf);
      rd_chk("mask", OFS_MASK, 32'h0000_dfff);
      wr_reg(OFS_MASK, 32'h0000_0002, 4'hf);
      pulse(16'h0001);
      @(negedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd_chk("pending", OFS_PENDING, 32'h0);
      pulse(16'h0002);
      @(negedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      rd_chk("pending", OFS_PENDING, 32'h2);
      rd_chk("clr reads", OFS_FLAGS_CLR, 32'h3);
      wr_reg(OFS_FLAGS_CLR, 32'h3, 4'hf);
      @(negedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask

   // A held request must win against every software clear
   task automatic t_level;
      @(posedge clk);
      fire <= 16'h0010;
      wr_reg(OFS_FLAGS_CLR, 32'h0000_0010, 4'hf);
      rd_chk("set beats w1c", OFS_FLAGS, 32'h0000_0010);
      wr_reg(OFS_FLAGS, 32'h0, 4'hf);
      rd_chk("set beats write", OFS_FLAGS, 32'h0000_0010);
      @(posedge clk);
      fire <= '0;
      repeat (2) @(posedge clk);
      wr_reg(OFS_FLAGS_CLR, 32'h0000_0010, 4'hf);
      rd_chk("released", OFS_FLAGS, 32'h0);
   endtask

   // Reset in mid-run with a flag and its mask bit both set
   task automatic t_midreset;
      wr_reg(OFS_MASK, 32'h0000_0001, 4'hf);
      pulse(16'h0001);
      @(negedge clk);
      chk("irq before reset", 32'h1, {31'h0, irq});
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      chk("irq after reset", 32'h0, {31'h0, irq});
      chk("flags_o after reset", 32'h0, {16'h0, flags});
      rd_chk("mask after reset", OFS_MASK, 32'h0);
      rd_chk("flags after reset", OFS_FLAGS, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Whole run is a few hundred cycles; this leaves wide margin
   initial begin
      #200000;
      miscompares++;
      summarize();
   end

   initial begin
      miscompares = 0;
      checked = 0;
      arst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 4'h0;
      be = 4'h0;
      wdata = 32'h0;
      fire = '0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_source(16'h0800, 16'h0800);
      t_source(16'h0200, 16'h0200);
      t_source(16'h0100, 16'h0100);
      t_source(16'h0020, 16'h0020);
      t_source(16'h0004, 16'h0004);
      t_source(16'h0002, 16'h0002);
      t_source(16'h0001, 16'h0001);
      t_source(16'h2000, 16'h0000);
      t_source(16'hffff, 16'hdfff);
      t_sw();
      t_irq();
      t_level();
      t_midreset();
      summarize();
   end
endmodule
`default_nettype wire

// ---- src_req_model.sv ----
// Peripheral request model driving the flag bank sources
`timescale 1ns/1ps
`default_nettype none
module src_req_model
   import ifs_bank_two_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          arst_n_i,
   input  wire flag_bits_type fire_i,
   output flag_bits_type      req_o
);
   // Requests leave flops of the same clock, as on-chip peripherals do
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         req_o <= '0;
      end else begin
         req_o <= fire_i;
      end
   end
endmodule
`default_nettype wire

// ---- sticky_flag_cell.sv ----
// One sticky request flag with software write and write-one-to-clear
`timescale 1ns/1ps
`default_nettype none

module sticky_flag_cell #(
   parameter bit IMPLEMENTED = 1'b1
) (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic set_i,
   input  wire logic wr_en_i,
   input  wire logic wr_val_i,
   input  wire logic clr_i,
   output logic      flag_o
);

   logic next_flag;

   // Hardware set beats any software clear in the same cycle
   always_comb begin
      if (!IMPLEMENTED) begin
         next_flag = 1'b0;
      end else if (set_i) begin
         next_flag = 1'b1;
      end else if (wr_en_i) begin
         next_flag = wr_val_i;
      end else begin
         next_flag = flag_o & ~clr_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag_o <= 1'b0;
      end else begin
         flag_o <= next_flag;
      end
   end

endmodule
`default_nettype wire
